//--- hdl/actcs_top.sv
// Purpose: chip-select/wait control for external areas two and three
// Assumes: internal access requests are synchronous to clk_i
// Notes:   one access at a time; wait extension pin is asynchronous
// Operation
// - each area's waveform code must be 00, ROM/RAM timing; others flagged illegal
// - width bit 0 gives 16-bit transfers, 1 gives 8-bit transfers
// - wait codes 0-7 insert that many waits; 1111 gives one plus external N
// - area two enable bit gates its chip select; resets enabled
// - area three enable bit gates its chip select; resets disabled
// - area two space select 0 covers all memory, 1 only its window
// - read recovery 00 two dummies, 01 one, 10 none; 11 illegal
// - area two width resets from the boot mode pin level
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`include "actcs_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module actcs_top
	import actcs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        boot_mode_pin_i,
	input  wire logic        wait_extend_i,
	input  wire logic        acc_req_i,
	input  wire logic        acc_read_i,
	input  wire logic        hit_two_window_i,
	input  wire logic        hit_three_window_i,
	output logic             acc_done_o,
	output logic             acc_width8_o,
	output logic             area_two_select_o,
	output logic             area_three_select_o
);
	import actcs_pkg::*;

	// ************************************************
	// pin synchronisers
	// ************************************************
	logic [1:0] boot_sync_r;
	logic [1:0] wext_sync_r;
	logic       boot_caught_r;
	always_ff @(posedge clk_i) begin
		boot_sync_r <= {boot_sync_r[0], boot_mode_pin_i};
		wext_sync_r <= {wext_sync_r[0], wait_extend_i};
	end

	// ************************************************
	// configuration register
	// ************************************************
	logic [31:0] cfg_r;
	logic [31:0] wmask;
	logic        bus_hit;
	logic        cfg_sel;
	assign cfg_sel = (adr_i == `ACTCS_BUS_CONTROL_ADDR);
	assign bus_hit = cyc_i && stb_i && !ack_o;
	assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}} & `ACTCS_CFG_MASK;

	// boot strap is sampled once after release, since reset takes constants only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_r         <= `ACTCS_RESET_LOW | `ACTCS_RESET_HIGH;
			boot_caught_r <= 1'b0;
		end else begin
			if (!boot_caught_r) begin
				cfg_r[`ACTCS_WIDTH_BIT] <= boot_sync_r[1];
				boot_caught_r           <= 1'b1;
			end else if (bus_hit && we_i && cfg_sel) begin
				cfg_r <= (cfg_r & ~wmask) | (dat_i & wmask);
			end
		end
	end

	// ************************************************
	// per-area decode
	// ************************************************
	logic [1:0]       en_a;
	logic [1:0]       w8_a;
	logic [1:0]       ext_a;
	logic [1:0]       bad_a;
	logic [1:0][2:0]  waits_a;
	logic [1:0][1:0]  recov_a;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_area
			actcs_area_decode u_dec (
				.cfg_i      (cfg_r[g*`ACTCS_AREA_STEP +: 16]),
				.enable_o   (en_a[g]),
				.width8_o   (w8_a[g]),
				.ext_wait_o (ext_a[g]),
				.waits_o    (waits_a[g]),
				.recov_o    (recov_a[g]),
				.bad_o      (bad_a[g])
			);
		end
	endgenerate

	// ************************************************
	// bus slave answer
	// ************************************************
	logic busy_r; // access in progress, shown in status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= bus_hit;
			if (bus_hit && !we_i) begin
				case (adr_i)
					`ACTCS_BUS_CONTROL_ADDR: dat_o <= cfg_r;
					`ACTCS_STATUS_ADDR:      dat_o <= {28'h0, bad_a, busy_r, 1'b0};
					default:                 dat_o <= 32'h0; // unmapped reads zero
				endcase
			end
		end
	end

	// ************************************************
	// area selection: area three window wins, area two may span all space
	// ************************************************
	logic hit_two;
	logic hit_three;
	assign hit_three = en_a[1] && hit_three_window_i;
	assign hit_two   = en_a[0] && !hit_three
		&& (!cfg_r[`ACTCS_SPACE_BIT] || hit_two_window_i);

	// ************************************************
	// access sequencer
	// ************************************************
	actcs_state_type state_r;
	logic       area_r;
	logic       read_r;
	logic [2:0] cnt_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r             <= ACTCS_IDLE;
			area_r              <= 1'b0;
			read_r              <= 1'b0;
			cnt_r               <= 3'h0;
			busy_r              <= 1'b0;
			acc_done_o          <= 1'b0;
			acc_width8_o        <= 1'b0;
			area_two_select_o   <= 1'b0;
			area_three_select_o <= 1'b0;
		end else begin
			acc_done_o <= 1'b0;
			case (state_r)
				ACTCS_IDLE: begin
					// requests outside both areas are left to other decoders
					if (acc_req_i && (hit_two || hit_three)) begin
						area_r              <= hit_three;
						read_r              <= acc_read_i;
						busy_r              <= 1'b1;
						acc_width8_o        <= hit_three ? w8_a[1] : w8_a[0];
						area_two_select_o   <= hit_two;
						area_three_select_o <= hit_three;
						state_r             <= ACTCS_SETUP;
					end
				end
				ACTCS_SETUP: begin
					cnt_r   <= waits_a[area_r];
					state_r <= ACTCS_WAIT;
				end
				ACTCS_WAIT: begin
					if (cnt_r != 3'h0) begin
						cnt_r <= cnt_r - 3'h1;
					end else if (ext_a[area_r] && wext_sync_r[1]) begin
						state_r <= ACTCS_XWAIT;
					end else begin
						state_r <= ACTCS_DONE;
					end
				end
				ACTCS_XWAIT: begin
					// external device stretches the access while it holds the pin
					if (!wext_sync_r[1]) begin
						state_r <= ACTCS_DONE;
					end
				end
				ACTCS_DONE: begin
					acc_done_o          <= 1'b1;
					area_two_select_o   <= 1'b0;
					area_three_select_o <= 1'b0;
					cnt_r               <= {1'b0, recov_a[area_r]};
					if (read_r && recov_a[area_r] != 2'h0) begin
						state_r <= ACTCS_RECOVER;
					end else begin
						busy_r  <= 1'b0;
						state_r <= ACTCS_IDLE;
					end
				end
				ACTCS_RECOVER: begin
					// dummy cycles let a slow device release the data bus
					if (cnt_r == 3'h1) begin
						busy_r  <= 1'b0;
						state_r <= ACTCS_IDLE;
					end
					cnt_r <= cnt_r - 3'h1;
				end
				default: state_r <= ACTCS_IDLE;
			endcase
		end
	end

	// ************************************************
	// checks
	// ************************************************
	area_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(area_two_select_o && area_three_select_o)) else $error("both area selects active");
	three_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(area_three_select_o) |-> $past(en_a[1])) else $error("area three selected while disabled");
	two_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(area_two_select_o) |-> $past(en_a[0])) else $error("area two selected while disabled");
	space_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(area_two_select_o) |-> $past(!cfg_r[`ACTCS_SPACE_BIT] || hit_two_window_i))
		else $error("area two outside its window");
	wave_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(cfg_r[7:6] != 2'h0) |-> bad_a[0]) else $error("bad waveform not flagged");
	boot_width_a: assert property (@(posedge clk_i)
		$rose(boot_caught_r) |-> cfg_r[`ACTCS_WIDTH_BIT] == $past(boot_sync_r[1]))
		else $error("boot width not strapped");
	zero_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_r == ACTCS_SETUP && waits_a[area_r] == 3'h0 && !ext_a[area_r]) |-> ##3 acc_done_o)
		else $error("zero-wait access too slow");
	recov_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(acc_done_o && read_r && recov_a[area_r] == 2'h2) |-> busy_r ##1 busy_r ##1 !busy_r)
		else $error("two-cycle recovery wrong");
	width_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(area_three_select_o) |-> acc_width8_o == $past(w8_a[1])) else $error("wrong width");
endmodule // actcs_top
`default_nettype wire

//--- shared/actcs_defines.svh
// Purpose: constants for the area two/three chip-select and wait controller
// Assumes: register reached over classic wishbone, 32-bit data
// Notes:   definitions only
`ifndef ACTCS_DEFINES_SVH
`define ACTCS_DEFINES_SVH

// ************************************************
// register map
// ************************************************
`define ACTCS_BUS_CONTROL_ADDR   8'h84
`define ACTCS_STATUS_ADDR        8'h88
`define ACTCS_CFG_MASK           32'h0bdf_0fdf
`define ACTCS_RESET_LOW          32'h0000_0805
`define ACTCS_RESET_HIGH         32'h0005_0000

// ************************************************
// field positions (area three sits 16 bits above area two)
// ************************************************
`define ACTCS_WAIT_LSB           0
`define ACTCS_WIDTH_BIT          4
`define ACTCS_WAVE_LSB           6
`define ACTCS_RECOV_LSB          8
`define ACTCS_SPACE_BIT          10
`define ACTCS_ENABLE_BIT         11
`define ACTCS_AREA_STEP          16

// ************************************************
// codes and timing counts
// ************************************************
`define ACTCS_WAVE_ROMRAM        2'h0
`define ACTCS_WAIT_EXT           4'hf
`define ACTCS_RECOV_BAD          2'h3

`endif

//--- shared/actcs_pkg.sv
// Purpose: types for the area two/three chip-select controller
// Assumes: used together with actcs_defines.svh
// Notes:   access sequencer states are gray coded in the order IDLE, SETUP, WAIT, XWAIT, DONE, RECOVER
package actcs_pkg;
	typedef enum logic [2:0] {
		ACTCS_IDLE    = 3'h0,
		ACTCS_SETUP   = 3'h1,
		ACTCS_WAIT    = 3'h3,
		ACTCS_XWAIT   = 3'h2,
		ACTCS_DONE    = 3'h6,
		ACTCS_RECOVER = 3'h7
	} actcs_state_type;
endpackage

//--- hdl/actcs_area_decode.sv
// Purpose: decodes one area's configuration half-word into timing values
// Assumes: field layout from actcs_defines.svh
// Notes:   prohibited codes are flagged, not repaired
`include "actcs_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module actcs_area_decode (
	input  wire logic [15:0] cfg_i,
	output logic             enable_o,
	output logic             width8_o,
	output logic             ext_wait_o,
	output logic [2:0]       waits_o,
	output logic [1:0]       recov_o,
	output logic             bad_o
);
	logic [3:0] wait_code;
	logic [1:0] rec_code;
	logic [1:0] wave_code;

	// field extraction
	assign wait_code  = cfg_i[`ACTCS_WAIT_LSB +: 4];
	assign rec_code   = cfg_i[`ACTCS_RECOV_LSB +: 2];
	assign wave_code  = cfg_i[`ACTCS_WAVE_LSB +: 2];
	assign enable_o   = cfg_i[`ACTCS_ENABLE_BIT];
	assign width8_o   = cfg_i[`ACTCS_WIDTH_BIT];
	assign ext_wait_o = (wait_code == `ACTCS_WAIT_EXT);
	// 1111 means one fixed cycle then external extension
	assign waits_o    = ext_wait_o ? 3'h1 : wait_code[2:0];
	// 00 -> 2 dummies, 01 -> 1, 10 -> none
	assign recov_o    = (rec_code == 2'h0) ? 2'h2 : (rec_code == 2'h1) ? 2'h1 : 2'h0;
	// prohibited waveform, wait or recovery codes
	assign bad_o      = (wave_code != `ACTCS_WAVE_ROMRAM)
		|| (wait_code[3] && !ext_wait_o) || (rec_code == `ACTCS_RECOV_BAD);
endmodule // actcs_area_decode
`default_nettype wire

//--- verif/actcs_mem_model.sv
// Purpose: external memory side, stretches each access
// Assumes: chip selects are active high
// Notes:   wait rises with the select and stays ext_i more cycles
`timescale 1ns/10ps
`default_nettype none
module actcs_mem_model (
	input  wire logic       clk_i,
	input  wire logic       sel_i,
	input  wire logic [3:0] ext_i,
	output logic            wait_o
);
	// ************************************************
	// wait stretch
	// ************************************************
	logic [3:0] cnt_r = 4'h0;
	logic       sel_r = 1'b0;
	logic       first;
	// a slow device asks for time only after it is selected
	always_ff @(posedge clk_i) begin
		sel_r <= sel_i;
		if (sel_i && !sel_r)
			cnt_r <= ext_i;
		else if (cnt_r != 4'h0)
			cnt_r <= cnt_r - 4'h1;
	end
	// answer in the select's first cycle so the synchronised pin is seen in time
	assign first  = sel_i && !sel_r && (ext_i != 4'h0);
	assign wait_o = first || (cnt_r != 4'h0);
endmodule // actcs_mem_model
`default_nettype wire

//--- verif/actcs_tb_top.sv
// Purpose: self-checking bench for the area two/three select block
// Assumes: classic wishbone, one cycle answer
// Notes:   cycle counts compared as differences where sync latency hides
`timescale 1ns/10ps
`default_nettype none
module actcs_tb_top;
	// ************************************************
	// stimulus and instances
	// ************************************************
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic        boot = 1'b0, req = 1'b0, rd = 1'b1, hit2 = 1'b0, hit3 = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0, dat_o, rdat;
	logic [3:0]  ext = 4'h0;
	logic        ack_o, done, w8, cs2, cs3, wext;
	int          n_mismatch = 0, tests_run = 0;
	// free running system clock
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	actcs_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.boot_mode_pin_i(boot), .wait_extend_i(wext), .acc_req_i(req), .acc_read_i(rd),
		.hit_two_window_i(hit2), .hit_three_window_i(hit3), .acc_done_o(done),
		.acc_width8_o(w8), .area_two_select_o(cs2), .area_three_select_o(cs3));
	actcs_mem_model mem_u (.clk_i(clk_i), .sel_i(cs2 | cs3), .ext_i(ext), .wait_o(wext));
	// verdict and compares
	task automatic give_verdict();
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t: value %h want %h", $time, got, exp);
		end
	endtask
	task automatic cmpn(input int got, input int exp);
		tests_run++;
		if (got != exp) begin
			n_mismatch++;
			$display("Error %0t: count %0d want %0d", $time, got, exp);
		end
	endtask
	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (ack_o === 1'b1)
				break;
		end
		rdat = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (i == 20) begin
			n_mismatch++;
			give_verdict();
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		cmp32(rdat, exp);
	endtask
	function automatic logic [15:0] half(input logic [3:0] wt, input logic wd, input logic [1:0] rc,
		input logic sp, input logic en);
		return {4'h0, en, sp, rc, 2'h0, 1'b0, wd, wt};
	endfunction
	// edges until done; zero means refused; s is selects and width mid access
	// drop releases the request once the select shows it was taken, so no second access starts
	task automatic run_acc(output int c, output logic [2:0] s, input logic drop);
		c = 0;
		s = 3'h0;
		for (int k = 1; k <= 40; k++) begin
			@(posedge clk_i);
			if (k == 2) begin
				s = {cs2, cs3, w8};
				if (drop)
					req <= 1'b0;
			end
			if (done === 1'b1) begin
				c = k;
				break;
			end
		end
	endtask
	task automatic acc(input logic h2, input logic h3, output int c, output logic [2:0] s);
		@(posedge clk_i);
		req <= 1'b1;
		hit2 <= h2;
		hit3 <= h3;
		run_acc(c, s, 1'b1);
		req <= 1'b0;
	endtask
	task automatic t_reset(input logic b, input logic [31:0] exp);
		boot <= b;
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rchk(8'h84, exp);
		wb(1'b1, 8'h40, 32'hffff_ffff);
		rchk(8'h40, 32'h0);
		rchk(8'h88, 32'h0);
	endtask
	// ************************************************
	// scenarios
	// ************************************************
	task automatic t_waits();
		int c;
		logic [2:0] s;
		for (int w = 0; w < 8; w++) begin
			wb(1'b1, 8'h84, {16'h0, half(w[3:0], 1'b0, 2'h2, 1'b0, 1'b1)});
			acc(1'b1, 1'b0, c, s);
			cmpn(c, 5 + w);
			cmp32({29'h0, s}, 32'h4);
		end
	endtask
	// both windows hit: area three wins, 8-bit
	task automatic t_width();
		int c;
		logic [2:0] s;
		wb(1'b1, 8'h84, {half(4'h0, 1'b1, 2'h2, 1'b0, 1'b1), half(4'h0, 1'b0, 2'h2, 1'b0, 1'b1)});
		rchk(8'h84, 32'h0a10_0a00);
		acc(1'b1, 1'b1, c, s);
		cmpn(c, 5);
		cmp32({29'h0, s}, 32'h3);
	endtask
	task automatic t_space();
		int c;
		logic [2:0] s;
		wb(1'b1, 8'h84, {16'h0, half(4'h0, 1'b0, 2'h2, 1'b1, 1'b1)});
		acc(1'b0, 1'b0, c, s);
		cmpn(c, 0);
		acc(1'b0, 1'b1, c, s);
		cmpn(c, 0);
		wb(1'b1, 8'h84, {16'h0, half(4'h0, 1'b0, 2'h2, 1'b0, 1'b1)});
		acc(1'b0, 1'b0, c, s);
		cmp32({29'h0, s}, 32'h4);
		wb(1'b1, 8'h84, {16'h0, half(4'h0, 1'b0, 2'h2, 1'b0, 1'b0)});
		acc(1'b1, 1'b0, c, s);
		cmpn(c, 0);
	endtask
	// done-to-done gap with the request held; last pass is a write
	task automatic t_recov();
		int c, g[4];
		logic [2:0] s;
		for (int r = 0; r < 4; r++) begin
			rd <= (r < 3);
			wb(1'b1, 8'h84, {16'h0, half(4'h0, 1'b0, (r < 3) ? r[1:0] : 2'h0, 1'b0, 1'b1)});
			@(posedge clk_i);
			req <= 1'b1;
			hit2 <= 1'b1;
			run_acc(c, s, 1'b0);
			run_acc(g[r], s, 1'b1);
			req <= 1'b0;
		end
		cmpn(g[0] - g[2], 2);
		cmpn(g[1] - g[2], 1);
		cmpn(g[3], g[2]);
		rd <= 1'b1;
	endtask
	task automatic t_ext();
		int c4, c8;
		logic [2:0] s;
		wb(1'b1, 8'h84, {16'h0, half(4'hf, 1'b0, 2'h2, 1'b0, 1'b1)});
		ext <= 4'h4;
		acc(1'b1, 1'b0, c4, s);
		ext <= 4'h8;
		acc(1'b1, 1'b0, c8, s);
		cmpn(c8 - c4, 4);
	endtask
	task automatic t_wave();
		wb(1'b1, 8'h84, 32'h0000_0840);
		rchk(8'h88, 32'h4);
		wb(1'b1, 8'h84, 32'h0040_0800);
		rchk(8'h88, 32'h8);
		wb(1'b1, 8'h84, 32'h0000_0b00);
		rchk(8'h88, 32'h4);
		wb(1'b1, 8'h84, 32'hffff_ffff);
		rchk(8'h84, 32'h0bdf_0fdf);
	endtask
	// main sequence
	initial begin
		t_reset(1'b0, 32'h0005_0805);
		t_waits();
		t_width();
		t_space();
		t_recov();
		t_ext();
		t_wave();
		t_reset(1'b1, 32'h0005_0815);
		give_verdict();
	end
endmodule // actcs_tb_top
`default_nettype wire
